// ### inc/fvml_consts.svh
// constants for the fault and voltage monitor logic
// assumes a 250 MHz clock and the output-set message layout below
`ifndef FVML_CONSTS_SVH
`define FVML_CONSTS_SVH

`define FVML_CLK_HZ          250000000
`define FVML_TICK_US         1000
`define FVML_TICK_CYCLES     ((`FVML_CLK_HZ / 1000000) * `FVML_TICK_US)
`define FVML_WDT_MS          2000
`define FVML_WDT_TOL_MS      100
`define FVML_WDT_TICKS       (`FVML_WDT_MS - `FVML_WDT_TOL_MS)
`define FVML_LOSS_MS         1000
`define FVML_FRAME_ADDR      8'h14
`define FVML_SERIAL_PORT     4'h5
`define FVML_HEARTBEAT_PORT  10
`define FVML_HEARTBEAT_BIT   7
`define FVML_FAULT_BIT       78
`define FVML_VOLT_BIT        79
`define FVML_NUM_IN          118
`define FVML_NUM_OUT         102
`define FVML_NUM_RATES       7

`endif

// ### inc/fvml_pkg.sv
// types for the fault and voltage monitor logic
// assumes fvml_consts.svh is on the include path
`include "fvml_consts.svh"

package fvml_pkg;
    typedef enum logic [1:0] {
        FVML_MSG_STATUS_REQ = 2'h1,
        FVML_MSG_SET_OUTPUT = 2'h2,
        FVML_MSG_OTHER      = 2'h3
    } fvml_msg_kind_t;

    typedef struct packed {
        logic                      valid;
        logic [7:0]                frame_addr;
        fvml_msg_kind_t            kind;
        logic                      ack_bit;
        logic [`FVML_NUM_OUT-1:0]  outputs;
    } fvml_msg_t;

    typedef struct packed {
        logic valid;
        logic ack_bit;
    } fvml_resp_t;

    typedef enum logic [2:0] {
        FVML_ST_LOST    = 3'b001,
        FVML_ST_WAITSET = 3'b010,
        FVML_ST_RUN     = 3'b100
    } fvml_state_t;
endpackage

// ### rtl/fvml_tick.sv
// prescaler giving a one-cycle pulse every tick period
// assumes the 250 MHz module clock
`timescale 1ns/1ps
`default_nettype none
`include "fvml_consts.svh"

module fvml_tick #(
    parameter int TICK_CYCLES = `FVML_TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    output logic      tick
);
    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

    logic [17:0] count;
    logic [17:0] next_count;

    always_comb begin
        next_count = (count == TICK_LAST) ? 18'h00000 : count + 18'h00001;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 18'h00000;
        end else begin
            count <= next_count;
        end
    end

    assign tick = (count == TICK_LAST);
endmodule
`default_nettype wire

// ### rtl/fvml_timeout.sv
// tick counter that flags expiry when not restarted in time
// assumes tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none

module fvml_timeout #(
    parameter int LIMIT = 1000
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic tick,
    input  wire logic restart,
    output logic      expired
);
    localparam logic [15:0] LIM = 16'(LIMIT);

    logic [15:0] count;
    logic [15:0] next_count;

    always_comb begin
        if (restart) begin
            next_count = 16'h0000;
        end else if (tick && count != LIM) begin
            next_count = count + 16'h0001;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count <= 16'h0000;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == LIM);
endmodule
`default_nettype wire

// ### rtl/fvml_top.sv
// fault and voltage monitor supervisory logic of the field interface module
// assumes decoded host messages arrive as one-cycle valid structs
`timescale 1ns/1ps
`default_nettype none
`include "fvml_consts.svh"

module fvml_top #(
    parameter int TICK_CYCLES = `FVML_TICK_CYCLES,
    parameter int LOSS_TICKS = `FVML_LOSS_MS,
    parameter int WDT_TICKS  = `FVML_WDT_TICKS
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire fvml_pkg::fvml_msg_t       host_msg,
    output fvml_pkg::fvml_resp_t           host_resp,
    input  wire logic [3:0]                host_port,
    input  wire logic                      heartbeat,
    input  wire logic                      supply_ok,
    input  wire logic                      power_down_n,
    input  wire logic                      reset_release,
    input  wire logic                      mains_sync,
    input  wire logic [2:0]                rate_jumper,
    output logic [15:0]                    aux_baud_div,
    input  wire logic [`FVML_NUM_IN-1:0]   field_in,
    output logic [`FVML_NUM_IN-1:0]        field_in_q,
    output logic [`FVML_NUM_OUT-1:0]       field_out,
    output logic [`FVML_NUM_OUT-1:0]       field_out_oe,
    output logic                           fault_monitor_out,
    output logic                           fault_monitor_oe,
    output logic                           voltage_monitor_out,
    output logic                           voltage_monitor_oe,
    output logic                           link_loss
);
    import fvml_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // prescaler and timers

    logic tick;
    logic hb_prev;
    logic hb_edge;
    logic wdt_expired;
    logic msg_here;
    logic loss_expired;

    assign hb_edge  = heartbeat ^ hb_prev;
    assign msg_here = host_msg.valid && host_port == `FVML_SERIAL_PORT
                      && host_msg.frame_addr == `FVML_FRAME_ADDR;

    fvml_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk   (clk),
        .reset (reset),
        .tick  (tick)
    );

    fvml_timeout #(.LIMIT(WDT_TICKS)) u_wdt (
        .clk     (clk),
        .reset   (reset),
        .tick    (tick),
        .restart (hb_edge),
        .expired (wdt_expired)
    );

    fvml_timeout #(.LIMIT(LOSS_TICKS)) u_loss (
        .clk     (clk),
        .reset   (reset),
        .tick    (tick),
        .restart (msg_here),
        .expired (loss_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // power-up sequence and link loss

    fvml_state_t               state;
    fvml_state_t               next_state;
    logic [`FVML_NUM_OUT-1:0]  cmd;
    logic [`FVML_NUM_OUT-1:0]  next_cmd;
    fvml_resp_t                next_resp;
    logic                      ports_open;
    logic                      next_ports_open;

    always_comb begin
        next_state = state;
        next_cmd   = cmd;
        next_resp  = '0;
        if (loss_expired && !msg_here) begin
            next_state = FVML_ST_LOST;
            next_cmd   = '0;
        end else if (msg_here) begin
            unique case (state)
                FVML_ST_LOST: begin
                    if (host_msg.kind == FVML_MSG_STATUS_REQ && host_msg.ack_bit) begin
                        next_state = FVML_ST_WAITSET;
                    end
                end
                FVML_ST_WAITSET: begin
                    // other messages leave the sequence intact
                    if (host_msg.kind == FVML_MSG_SET_OUTPUT) begin
                        next_cmd = host_msg.outputs;
                        if (!host_msg.outputs[`FVML_FAULT_BIT]
                            && !host_msg.outputs[`FVML_VOLT_BIT]) begin
                            next_state = FVML_ST_RUN;
                        end
                    end
                end
                FVML_ST_RUN: begin
                    if (host_msg.kind == FVML_MSG_SET_OUTPUT) begin
                        next_cmd = host_msg.outputs;
                    end
                end
                default: begin
                    next_state = FVML_ST_LOST;
                end
            endcase
            if (host_msg.kind == FVML_MSG_STATUS_REQ && host_msg.ack_bit) begin
                next_resp.valid   = 1'b1;
                next_resp.ack_bit = 1'b1;
            end
        end
        next_ports_open = ports_open;
        if (!power_down_n) begin
            next_ports_open = 1'b1;
        end else if (reset_release) begin
            next_ports_open = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= FVML_ST_LOST;
            cmd        <= '0;
            host_resp  <= '0;
            ports_open <= 1'b1;
            hb_prev    <= 1'b0;
        end else begin
            state      <= next_state;
            cmd        <= next_cmd;
            host_resp  <= next_resp;
            ports_open <= next_ports_open;
            hb_prev    <= heartbeat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor gates and field outputs; true is 1 here

    logic run;
    logic wdt_true;
    logic fcu_fault_true;
    logic fcu_volt_true;
    logic next_fm;
    logic next_vm;
    logic [`FVML_NUM_OUT-1:0] next_out;

    assign run            = (state == FVML_ST_RUN);
    assign wdt_true       = !wdt_expired;
    assign fcu_fault_true = run && !cmd[`FVML_FAULT_BIT];
    assign fcu_volt_true  = run && !cmd[`FVML_VOLT_BIT];

    always_comb begin
        next_fm  = wdt_true && supply_ok && fcu_fault_true;
        next_vm  = wdt_true && supply_ok && fcu_volt_true;
        next_out = run ? cmd : '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fault_monitor_out   <= 1'b0;
            voltage_monitor_out <= 1'b0;
            field_out           <= '0;
            field_in_q          <= '0;
        end else begin
            fault_monitor_out   <= next_fm;
            voltage_monitor_out <= next_vm;
            field_out           <= next_out;
            field_in_q          <= field_in;
        end
    end

    assign fault_monitor_oe   = !ports_open;
    assign voltage_monitor_oe = !ports_open;
    assign field_out_oe       = {`FVML_NUM_OUT{!ports_open}};
    assign link_loss          = (state != FVML_ST_RUN) && (state != FVML_ST_WAITSET);

    ////////////////////////////////////////////////////////////////////////
    // auxiliary serial port rate select, divisor for 16x oversampling

    logic [15:0] next_div;

    always_comb begin
        unique case (rate_jumper)
            3'h0: next_div = 16'(`FVML_CLK_HZ / (300 * 16));
            3'h1: next_div = 16'(`FVML_CLK_HZ / (1200 * 16));
            3'h2: next_div = 16'(`FVML_CLK_HZ / (2400 * 16));
            3'h3: next_div = 16'(`FVML_CLK_HZ / (4800 * 16));
            3'h4: next_div = 16'(`FVML_CLK_HZ / (9600 * 16));
            3'h5: next_div = 16'(`FVML_CLK_HZ / (19200 * 16));
            default: next_div = 16'(`FVML_CLK_HZ / (38400 * 16));
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            aux_baud_div <= 16'h0000;
        end else begin
            aux_baud_div <= next_div;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    wire unused_ok = mains_sync;

    wdt_false_a: assert property (@(posedge clk) disable iff (reset)
        wdt_expired |=> !fault_monitor_out && !voltage_monitor_out)
        else $error("watchdog expiry did not force monitors false");
    supply_false_a: assert property (@(posedge clk) disable iff (reset)
        !supply_ok |=> !fault_monitor_out && !voltage_monitor_out)
        else $error("bad supply did not force monitors false");
    status_ack_a: assert property (@(posedge clk) disable iff (reset)
        msg_here && host_msg.kind == FVML_MSG_STATUS_REQ && host_msg.ack_bit
        |=> host_resp.valid && host_resp.ack_bit)
        else $error("status request not answered with ack");
    status_clear_a: assert property (@(posedge clk) disable iff (reset)
        state == FVML_ST_LOST && msg_here && !loss_expired
        && host_msg.kind == FVML_MSG_STATUS_REQ && host_msg.ack_bit |=> !link_loss)
        else $error("status request did not clear link loss");
    set_run_a: assert property (@(posedge clk) disable iff (reset)
        state == FVML_ST_WAITSET && msg_here && !loss_expired
        && host_msg.kind == FVML_MSG_SET_OUTPUT
        && !host_msg.outputs[`FVML_FAULT_BIT] && !host_msg.outputs[`FVML_VOLT_BIT]
        |=> state == FVML_ST_RUN)
        else $error("output-set did not enter run");
    order_hold_a: assert property (@(posedge clk) disable iff (reset)
        state == FVML_ST_LOST |=> !fault_monitor_out && !voltage_monitor_out)
        else $error("monitors true without power-up order");
    loss_blank_a: assert property (@(posedge clk) disable iff (reset)
        loss_expired && !msg_here |=> link_loss
        ##1 (field_out == '0 && !fault_monitor_out && !voltage_monitor_out))
        else $error("link loss did not blank outputs");
    open_ports_a: assert property (@(posedge clk) disable iff (reset)
        !power_down_n |=> !fault_monitor_oe && field_out_oe == '0)
        else $error("ports driven during power down");
    fault_bit_a: assert property (@(posedge clk) disable iff (reset)
        run && cmd[`FVML_FAULT_BIT] |=> !fault_monitor_out)
        else $error("fault bit set but monitor true");

    volt_bit_a: assert property (@(posedge clk) disable iff (reset)
        run && cmd[`FVML_VOLT_BIT] |=> !voltage_monitor_out)
        else $error("voltage bit set but monitor true");
    gates_true_a: assert property (@(posedge clk) disable iff (reset)
        wdt_true && supply_ok && run && !cmd[`FVML_FAULT_BIT] && !cmd[`FVML_VOLT_BIT]
        |=> fault_monitor_out && voltage_monitor_out)
        else $error("monitors false with all gate inputs true");
    wdt_restart_a: assert property (@(posedge clk) disable iff (reset)
        wdt_expired && hb_edge |=> !wdt_expired)
        else $error("heartbeat edge did not restart watchdog");
    ports_drive_a: assert property (@(posedge clk) disable iff (reset)
        power_down_n && reset_release
        |=> fault_monitor_oe && voltage_monitor_oe && (&field_out_oe))
        else $error("ports not driven after reset release");
    addr_filter_a: assert property (@(posedge clk) disable iff (reset)
        host_msg.valid && (host_port != `FVML_SERIAL_PORT
        || host_msg.frame_addr != `FVML_FRAME_ADDR) |=> !host_resp.valid)
        else $error("answer to a message for another port or address");
    nack_ignore_a: assert property (@(posedge clk) disable iff (reset)
        msg_here && host_msg.kind == FVML_MSG_STATUS_REQ && !host_msg.ack_bit
        |=> !host_resp.valid)
        else $error("status request without ack was answered");
    wait_hold_a: assert property (@(posedge clk) disable iff (reset)
        state == FVML_ST_WAITSET |=> !fault_monitor_out && !voltage_monitor_out)
        else $error("monitors true before output-set");
    out_blank_a: assert property (@(posedge clk) disable iff (reset)
        !run |=> field_out == '0)
        else $error("field outputs driven outside run");

    run_c: cover property (@(posedge clk) disable iff (reset) state == FVML_ST_RUN);
    loss_c: cover property (@(posedge clk) disable iff (reset)
        state == FVML_ST_RUN ##1 state == FVML_ST_LOST);
    wdt_c: cover property (@(posedge clk) disable iff (reset) run && wdt_expired);
    status_c: cover property (@(posedge clk) disable iff (reset) host_resp.valid);
    supply_c: cover property (@(posedge clk) disable iff (reset) run && !supply_ok);
endmodule
`default_nettype wire

// ### sim/fvml_host_model.sv
// host processor model sending decoded messages to the monitor logic
// assumes the bench calls send() at any time and reads resp_count
`timescale 1ns/1ps
`default_nettype none
`include "fvml_consts.svh"

module fvml_host_model (
    input  wire logic           clk,
    output fvml_pkg::fvml_msg_t host_msg,
    output logic [3:0]          host_port,
    input  wire fvml_pkg::fvml_resp_t host_resp
);
    import fvml_pkg::*;

    int resp_count = 0;

    initial begin
        host_msg = '0;
        host_port = 4'h0;
    end

    // count acknowledged answers
    always @(posedge clk) begin
        if (host_resp.valid === 1'b1 && host_resp.ack_bit === 1'b1) begin
            resp_count <= resp_count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one-cycle message, fields scrambled once released
    task automatic send(input fvml_msg_kind_t k, input logic ack,
                        input logic [`FVML_NUM_OUT-1:0] d, input logic [3:0] p,
                        input logic [7:0] a);
        @(negedge clk);
        host_msg <= {1'b1, a, k, ack, d};
        host_port <= p;
        @(negedge clk);
        host_msg <= {1'b0, ~a, ~k, ~ack, ~d};
        host_port <= ~p;
    endtask
endmodule
`default_nettype wire

// ### sim/fault_voltage_monitor_logic_test.sv
// self-checking bench for the monitor logic
// assumes fvml_top with shortened tick counts and the host model
`timescale 1ns/1ps
`default_nettype none
`include "fvml_consts.svh"

module fault_voltage_monitor_logic_test;
    import fvml_pkg::*;

    localparam int TICK = 1000;
    localparam int HB   = 200;
    localparam int LOSS = 5;
    localparam int WDT  = 2;

    logic                     clk, reset, heartbeat, supply_ok, hb_en;
    logic                     power_down_n, reset_release;
    fvml_msg_t                host_msg;
    fvml_resp_t               host_resp;
    logic [3:0]               host_port;
    logic [2:0]               rate_jumper;
    logic [15:0]              aux_baud_div;
    logic [117:0]             field_in, field_in_q;
    logic [101:0]             field_out, field_out_oe, data;
    logic                     fault_monitor_out, fault_monitor_oe;
    logic                     voltage_monitor_out, voltage_monitor_oe, link_loss;
    int                       errors = 0;
    int                       total_checks = 0;
    int                       hbps[8] = '{3, 12, 24, 48, 96, 192, 384, 384};

    fvml_top #(.TICK_CYCLES(TICK), .LOSS_TICKS(LOSS), .WDT_TICKS(WDT)) uut (
        .clk(clk), .reset(reset), .host_msg(host_msg), .host_resp(host_resp),
        .host_port(host_port), .heartbeat(heartbeat), .supply_ok(supply_ok),
        .power_down_n(power_down_n), .reset_release(reset_release), .mains_sync(1'b0),
        .rate_jumper(rate_jumper), .aux_baud_div(aux_baud_div), .field_in(field_in),
        .field_in_q(field_in_q), .field_out(field_out), .field_out_oe(field_out_oe),
        .fault_monitor_out(fault_monitor_out), .fault_monitor_oe(fault_monitor_oe),
        .voltage_monitor_out(voltage_monitor_out),
        .voltage_monitor_oe(voltage_monitor_oe), .link_loss(link_loss));

    fvml_host_model host (.clk(clk), .host_msg(host_msg), .host_port(host_port),
                          .host_resp(host_resp));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // heartbeat toggling while enabled
    initial begin
        heartbeat = 1'b0;
        forever begin
            repeat (HB) @(negedge clk);
            if (hb_en) heartbeat = ~heartbeat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic msg(input fvml_msg_kind_t k, input logic ack, input logic [101:0] d);
        host.send(k, ack, d, `FVML_SERIAL_PORT, `FVML_FRAME_ADDR);
    endtask

    task automatic mons(input logic [1:0] exp);
        cyc(5);
        check({fault_monitor_out, voltage_monitor_out}, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic power_cycle();
        power_down_n = 1'b0;
        reset_release = 1'b0;
        cyc(3);
        check({field_out_oe, fault_monitor_oe, voltage_monitor_oe}, '0);
        power_down_n = 1'b1;
        cyc(3);
        check({field_out_oe, fault_monitor_oe, voltage_monitor_oe}, '0);
        reset_release = 1'b1;
        cyc(3);
        check({field_out_oe, fault_monitor_oe, voltage_monitor_oe}, {104{1'b1}});
    endtask

    task automatic t_order();
        int r;
        r = host.resp_count;
        check(link_loss, 1'b1);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, '0);
        msg(FVML_MSG_STATUS_REQ, 1'b0, '0);
        host.send(FVML_MSG_STATUS_REQ, 1'b1, '0, 4'h4, `FVML_FRAME_ADDR);
        host.send(FVML_MSG_STATUS_REQ, 1'b1, '0, `FVML_SERIAL_PORT, 8'h15);
        mons(2'b00);
        check({host.resp_count, link_loss}, {r, 1'b1});
        msg(FVML_MSG_STATUS_REQ, 1'b1, '0);
        cyc(2);
        check({host.resp_count, link_loss}, {r + 1, 1'b0});
        repeat (3) msg(FVML_MSG_OTHER, 1'b0, data);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data | (102'h1 << 78));
        mons(2'b00);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data);
        mons(2'b11);
        check(field_out, data);
    endtask

    task automatic t_gates();
        int e;
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data | (102'h1 << 78));
        mons(2'b01);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data | (102'h1 << 79));
        mons(2'b10);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data);
        supply_ok = 1'b0;
        mons(2'b00);
        supply_ok = 1'b1;
        mons(2'b11);
        field_in = {59{2'b10}};
        cyc(2);
        check(field_in_q, {59{2'b10}});
        for (int i = 0; i < 8; i++) begin
            rate_jumper = i[2:0];
            cyc(3);
            e = `FVML_CLK_HZ / (1600 * hbps[i]);
            check(aux_baud_div + 17'h1 >= e && aux_baud_div <= e + 1, 1'b1);
        end
    endtask

    task automatic t_watchdog();
        int n;
        msg(FVML_MSG_OTHER, 1'b0, data);
        hb_en = 1'b0;
        n = 0;
        while (fault_monitor_out === 1'b1 && n < 3 * TICK + 10) begin
            @(negedge clk);
            n++;
        end
        check(n >= (WDT - 1) * TICK - HB && n <= WDT * TICK + 10, 1'b1);
        check({voltage_monitor_out, link_loss}, 2'b00);
        hb_en = 1'b1;
        n = 0;
        while (fault_monitor_out !== 1'b1 && n < HB + 10) begin
            @(negedge clk);
            n++;
        end
        mons(2'b11);
    endtask

    task automatic t_loss();
        int n;
        msg(FVML_MSG_OTHER, 1'b0, data);
        n = 0;
        while (link_loss !== 1'b1 && n < (LOSS + 1) * TICK + 10) begin
            @(negedge clk);
            n++;
        end
        check(n >= (LOSS - 1) * TICK && n <= (LOSS + 1) * TICK + 10, 1'b1);
        mons(2'b00);
        check(field_out, '0);
        msg(FVML_MSG_SET_OUTPUT, 1'b0, data);
        mons(2'b00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // cut a hang well past the longest expected run
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        hb_en = 1'b1;
        supply_ok = 1'b1;
        power_down_n = 1'b0;
        reset_release = 1'b0;
        rate_jumper = 3'h0;
        field_in = '0;
        data = {34{3'b101}} & ~(102'h3 << 78);
        repeat (12) @(negedge clk);
        reset = 1'b0;
        power_cycle();
        t_order();
        t_gates();
        t_watchdog();
        t_loss();
        power_cycle();
        give_verdict();
    end
endmodule
`default_nettype wire
